// *** logic/gfm_pkg.sv ***
// constants, types and pin numbering for the gpio function multiplexer
// assumes one 20 MHz system clock and pad cells that resolve the pin level from out/oe
//
// How it works
// R1: selection zero makes the pin a plain input with its driver off
// R2: selection one drives the pin from the port output data value
// R3: port c offers raw flash, emmc card, spi boot flash, boot media selects
// R4: port f offers first card port, debug test port and console uart
// R5: port g offers second card port, flow-control uart, debug port, pll lock debug
// R6: port g pins 10-14 carry audio serial 2 and self-test result bits
// R7: port h offers uarts, audio serial 3, spi 1, pwm and i2c per pin
// R8: port i offers ethernet, management, phy clock and transport stream input
// R9: port l offers only the standby i2c clock and data
// R10: selection six feeds the pin to its own interrupt line on ports c-i
// R11: strap high starts media boot search, low forces firmware upgrade
// R12: debug select input picks which pin group gets the debug port
// R13: system reset pin is active low
// R14: port g pin 10 selection three drives the slow clock open drain
// R15: blank cells and values above six route nothing and keep driver off
// R16: selections reset to an inactive high-impedance value
`default_nettype none

package gfm_pkg;

    // pin numbering: all ports packed into one flat index space
    localparam int unsigned NPIN = 74;
    localparam int unsigned NALT = 4;
    localparam int unsigned SELW = 3;
    localparam int unsigned BASE_C = 0;
    localparam int unsigned BASE_F = 17;
    localparam int unsigned BASE_G = 24;
    localparam int unsigned BASE_H = 44;
    localparam int unsigned BASE_I = 55;
    localparam int unsigned BASE_L = 72;
    localparam int unsigned NPIN_C = 17;
    localparam int unsigned NPIN_F = 7;
    localparam int unsigned NPIN_G = 20;
    localparam int unsigned NPIN_H = 11;
    localparam int unsigned NPIN_I = 17;

    // selection codes
    localparam logic [2:0] SEL_INPUT = 3'h0;
    localparam logic [2:0] SEL_OUTPUT = 3'h1;
    localparam logic [2:0] SEL_ALT_FIRST = 3'h2;
    localparam logic [2:0] SEL_ALT_LAST = 3'h5;
    localparam logic [2:0] SEL_IRQ = 3'h6;
    localparam logic [2:0] SEL_INACTIVE = 3'h7;

    // special pins
    localparam int unsigned PIN_SLOW_CLK = BASE_G + 10;
    localparam logic [2:0] SEL_SLOW_CLK = 3'h3;
    localparam logic [2:0] SEL_DBG_F = 3'h3;
    localparam logic [2:0] SEL_DBG_G = 3'h4;

    // reset values
    localparam logic RST_BOOT_SEARCH = 1'b0;
    localparam logic RST_RESET_REQ = 1'b0;

    // slow clock rate, informational for the fanout path
    localparam real SLOW_CLK_KHZ = 32.768;

    typedef struct packed {
        logic [NPIN-1:0][SELW-1:0] sel;
        logic [NPIN-1:0] pad_out;
        logic [NPIN-1:0] pad_oe;
        logic [NPIN*NALT-1:0] alt_in;
        logic [NPIN-1:0] gpio_in;
        logic [NPIN-1:0] irq_line;
        logic strap_done;
        logic boot_search;
        logic reset_req;
    } gfm_state_s;

endpackage : gfm_pkg

`default_nettype wire

// *** logic/gfm_mux.sv ***
// per-pin function multiplexer between peripherals and port pins c, f, g, h, i, l
// assumes pad cells outside resolve the wire from pad_out_o / pad_oe_o
// assumes peripherals present out/oe per pin per alternate slot (selection 2..5)
// assumes the reset pin and strap are already synchronous to core_clk_i
`timescale 1ns/1ns
`default_nettype none

module gfm_mux (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // selection load, one write enable per pin
    input wire logic [gfm_pkg::NPIN-1:0] sel_wr_en_i,
    input wire logic [gfm_pkg::NPIN*gfm_pkg::SELW-1:0] sel_wdata_i,
    output logic [gfm_pkg::NPIN*gfm_pkg::SELW-1:0] sel_state_o,
    // general-purpose data
    input wire logic [gfm_pkg::NPIN-1:0] gpio_out_i,
    output logic [gfm_pkg::NPIN-1:0] gpio_in_o,
    // pads
    input wire logic [gfm_pkg::NPIN-1:0] pad_in_i,
    output logic [gfm_pkg::NPIN-1:0] pad_out_o,
    output logic [gfm_pkg::NPIN-1:0] pad_oe_o,
    // peripheral side, slot = selection minus two
    input wire logic [gfm_pkg::NPIN*gfm_pkg::NALT-1:0] alt_out_i,
    input wire logic [gfm_pkg::NPIN*gfm_pkg::NALT-1:0] alt_oe_i,
    output logic [gfm_pkg::NPIN*gfm_pkg::NALT-1:0] alt_in_o,
    // external interrupt lines
    output logic [gfm_pkg::NPIN_C-1:0] port_c_interrupt_line_o,
    output logic [gfm_pkg::NPIN_F-1:0] port_f_interrupt_line_o,
    output logic [gfm_pkg::NPIN_G-1:0] port_g_interrupt_line_o,
    output logic [gfm_pkg::NPIN_H-1:0] port_h_interrupt_line_o,
    output logic [gfm_pkg::NPIN_I-1:0] port_i_interrupt_line_o,
    // system control
    input wire logic debug_port_sel_i,
    input wire logic boot_mode_strap_i,
    output logic boot_mode_valid_o,
    output logic media_boot_search_o,
    output logic forced_upgrade_o,
    input wire logic sys_reset_pin_n_i,
    output logic reset_request_o
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // table cell present for pin and selection
    // a blank cell returns zero and the pin stays undriven
    function automatic logic gfm_cell_ok(input int unsigned p, input logic [2:0] fn);
        logic ok;
        ok = 1'b0;
        case (fn)
            3'h2: begin // see R3 R4 R5 R6 R7 R8 R9
                // all of c, i and l; f0-5, g0-18, h0-3 and h5-8
                ok = (p < gfm_pkg::BASE_F + 6) ||
                     (p >= gfm_pkg::BASE_G && p <= gfm_pkg::BASE_G + 18) ||
                     (p >= gfm_pkg::BASE_H && p <= gfm_pkg::BASE_H + 3) ||
                     (p >= gfm_pkg::BASE_H + 5 && p <= gfm_pkg::BASE_H + 8) ||
                     (p >= gfm_pkg::BASE_I && p < gfm_pkg::NPIN);
            end
            3'h3: begin // see R3 R4 R5 R6 R7 R8
                // c card pins, f0-5, g8, g10, g13, g14, h2, h4-10 and all of i
                ok = (p <= 1) || (p == 5) || (p == 6) || (p >= 8 && p <= 11) ||
                     (p >= 13 && p < gfm_pkg::BASE_F) ||
                     (p >= gfm_pkg::BASE_F && p <= gfm_pkg::BASE_F + 5) ||
                     (p == gfm_pkg::BASE_G + 8) || (p == gfm_pkg::BASE_G + 10) ||
                     (p == gfm_pkg::BASE_G + 13) || (p == gfm_pkg::BASE_G + 14) ||
                     (p == gfm_pkg::BASE_H + 2) ||
                     (p >= gfm_pkg::BASE_H + 4 && p < gfm_pkg::BASE_I) ||
                     (p >= gfm_pkg::BASE_I && p < gfm_pkg::BASE_L);
            end
            3'h4: begin // see R3 R5 R6 R7 R8
                // c spi pins, g debug and self-test pins, g19, h0-3, h5-10, all of i
                ok = (p == 0) || (p >= 2 && p <= 4) || (p == 7) || (p == 15) || (p == 16) ||
                     (p >= gfm_pkg::BASE_G + 6 && p <= gfm_pkg::BASE_G + 9) ||
                     (p >= gfm_pkg::BASE_G + 11 && p <= gfm_pkg::BASE_G + 14) ||
                     (p == gfm_pkg::BASE_G + 19) ||
                     (p >= gfm_pkg::BASE_H && p <= gfm_pkg::BASE_H + 3) ||
                     (p >= gfm_pkg::BASE_H + 5 && p < gfm_pkg::BASE_I) ||
                     (p >= gfm_pkg::BASE_I && p < gfm_pkg::BASE_L);
            end
            3'h5: begin // see R3 R7 R8
                // c boot selects, g15-18, h0-9 and all of i
                ok = (p >= 3 && p <= 6) ||
                     (p >= gfm_pkg::BASE_G + 15 && p <= gfm_pkg::BASE_G + 18) ||
                     (p >= gfm_pkg::BASE_H && p <= gfm_pkg::BASE_H + 9) ||
                     (p >= gfm_pkg::BASE_I && p < gfm_pkg::BASE_L);
            end
            3'h6: begin
                // every port but l has one line per pin
                ok = (p < gfm_pkg::BASE_L); // see R10
            end
            default: begin
                // 0, 1 and 7 carry no peripheral
                ok = 1'b0; // see R15
            end
        endcase
        return ok;
    endfunction : gfm_cell_ok

    // debug test port cell: suppressed unless its group is the chosen one
    // the other group's cells read as blank, so two pin groups never
    // carry the debug signals at the same time
    function automatic logic gfm_debug_blocked(input int unsigned p, input logic [2:0] fn,
                                               input logic sel_f);
        logic f_cell;
        logic g_cell;
        f_cell = (fn == gfm_pkg::SEL_DBG_F) &&
                 (p == gfm_pkg::BASE_F || p == gfm_pkg::BASE_F + 1 ||
                  p == gfm_pkg::BASE_F + 3 || p == gfm_pkg::BASE_F + 5);
        g_cell = (fn == gfm_pkg::SEL_DBG_G) &&
                 (p >= gfm_pkg::BASE_G + 6 && p <= gfm_pkg::BASE_G + 9);
        return (f_cell && !sel_f) || (g_cell && sel_f); // see R12
    endfunction : gfm_debug_blocked

    ////////////////////////////////////////////////////////////////////////////
    // state

    // whole block state, one packed struct registered every clock
    gfm_pkg::gfm_state_s cur_reg;
    gfm_pkg::gfm_state_s cur_next;

    // next-state logic for every pin and the system control bits
    always_comb begin
        int unsigned slot;
        logic [2:0] s;
        logic ok;
        slot = 0;
        s = gfm_pkg::SEL_INACTIVE;
        ok = 1'b0;
        cur_next = cur_reg;
        cur_next.alt_in = '0;
        cur_next.irq_line = '0;
        cur_next.gpio_in = pad_in_i;
        // per-pin load and routing
        for (int unsigned p = 0; p < gfm_pkg::NPIN; p++) begin
            if (sel_wr_en_i[p]) begin
                cur_next.sel[p] = sel_wdata_i[p*gfm_pkg::SELW +: gfm_pkg::SELW];
            end
            // outputs follow the registered selection one clock later, two clocks behind a write
            s = cur_reg.sel[p];
            ok = gfm_cell_ok(p, s) && !gfm_debug_blocked(p, s, debug_port_sel_i);
            cur_next.pad_out[p] = 1'b0;
            cur_next.pad_oe[p] = 1'b0;
            if (s == gfm_pkg::SEL_INPUT) begin
                cur_next.pad_oe[p] = 1'b0; // see R1
            end else if (s == gfm_pkg::SEL_OUTPUT) begin
                cur_next.pad_out[p] = gpio_out_i[p]; // see R2
                cur_next.pad_oe[p] = 1'b1; // see R2
            end else if (s >= gfm_pkg::SEL_ALT_FIRST && s <= gfm_pkg::SEL_ALT_LAST && ok) begin
                // slot picks the peripheral lane; the pad level goes to that lane only
                slot = p * gfm_pkg::NALT + 32'(s - gfm_pkg::SEL_ALT_FIRST);
                cur_next.alt_in[slot] = pad_in_i[p];
                // open drain: only ever pulls low, the pull-up on the wire makes
                // the high, so the peripheral's enable is ignored on this cell
                if (p == gfm_pkg::PIN_SLOW_CLK && s == gfm_pkg::SEL_SLOW_CLK) begin
                    cur_next.pad_out[p] = 1'b0; // see R14
                    cur_next.pad_oe[p] = ~alt_out_i[slot]; // see R14
                end else begin
                    cur_next.pad_out[p] = alt_out_i[slot];
                    cur_next.pad_oe[p] = alt_oe_i[slot];
                end
            end else if (s == gfm_pkg::SEL_IRQ && ok) begin
                cur_next.irq_line[p] = pad_in_i[p]; // see R10
            end
        end
        // strap taken once, on the first cycle after reset release
        // later strap changes are ignored until the next reset
        if (!cur_reg.strap_done) begin
            cur_next.strap_done = 1'b1;
            cur_next.boot_search = boot_mode_strap_i; // see R11
        end
        cur_next.reset_req = ~sys_reset_pin_n_i; // see R13
        // synchronous reset overrides every load above
        if (srst_i) begin
            for (int unsigned p = 0; p < gfm_pkg::NPIN; p++) begin
                cur_next.sel[p] = gfm_pkg::SEL_INACTIVE; // see R16
            end
            cur_next.pad_out = '0;
            cur_next.pad_oe = '0;
            cur_next.alt_in = '0;
            cur_next.gpio_in = '0;
            cur_next.irq_line = '0;
            cur_next.strap_done = 1'b0;
            cur_next.boot_search = gfm_pkg::RST_BOOT_SEARCH;
            cur_next.reset_req = gfm_pkg::RST_RESET_REQ;
        end
    end

    // state register
    always_ff @(posedge core_clk_i) begin
        cur_reg <= cur_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // pads, peripherals and readback
    // all registered: pads follow a new selection two clocks after the write
    assign pad_out_o = cur_reg.pad_out;
    assign pad_oe_o = cur_reg.pad_oe;
    assign alt_in_o = cur_reg.alt_in;
    assign gpio_in_o = cur_reg.gpio_in;
    assign sel_state_o = cur_reg.sel;

    // interrupt lines, index within port equals pin index
    // only a pin set to selection six can raise its line
    assign port_c_interrupt_line_o = cur_reg.irq_line[gfm_pkg::BASE_C +: gfm_pkg::NPIN_C];
    assign port_f_interrupt_line_o = cur_reg.irq_line[gfm_pkg::BASE_F +: gfm_pkg::NPIN_F];
    assign port_g_interrupt_line_o = cur_reg.irq_line[gfm_pkg::BASE_G +: gfm_pkg::NPIN_G];
    assign port_h_interrupt_line_o = cur_reg.irq_line[gfm_pkg::BASE_H +: gfm_pkg::NPIN_H];
    assign port_i_interrupt_line_o = cur_reg.irq_line[gfm_pkg::BASE_I +: gfm_pkg::NPIN_I];

    // boot decision and reset request
    // both boot outputs stay low until the strap has been taken
    assign boot_mode_valid_o = cur_reg.strap_done;
    assign media_boot_search_o = cur_reg.strap_done & cur_reg.boot_search; // see R11
    assign forced_upgrade_o = cur_reg.strap_done & ~cur_reg.boot_search; // see R11
    assign reset_request_o = cur_reg.reset_req;

endmodule : gfm_mux

`default_nettype wire

// *** test/gfm_pad_model.sv ***
// pad model: far-side devices and pull-ups on the pins
// assumes one bit per flat pin index
`timescale 1ns/1ns
`default_nettype none
module gfm_pad_model (
    // design side
    input wire logic [73:0] out_i,
    input wire logic [73:0] oe_i,
    // far-side device
    input wire logic [73:0] drv_i,
    input wire logic [73:0] drv_en_i,
    // resolved level
    output logic [73:0] pin_o
);
    // design driver, else device, else pull-up (open-drain release)
    assign pin_o = (oe_i & out_i) | (~oe_i & drv_en_i & drv_i) | (~oe_i & ~drv_en_i);
endmodule : gfm_pad_model
`default_nettype wire

// *** test/gfm_mux_monitor.sv ***
// checker on the ports of gfm_mux
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module gfm_mux_monitor (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // selections and pads
    input wire logic [221:0] sel_state_o,
    input wire logic [73:0] gpio_out_i,
    input wire logic [73:0] pad_in_i,
    input wire logic [73:0] pad_out_o,
    input wire logic [73:0] pad_oe_o,
    input wire logic [295:0] alt_out_i,
    input wire logic [295:0] alt_oe_i,
    input wire logic [16:0] port_c_interrupt_line_o,
    // system control
    input wire logic debug_port_sel_i,
    input wire logic boot_mode_strap_i,
    input wire logic boot_mode_valid_o,
    input wire logic media_boot_search_o,
    input wire logic forced_upgrade_o,
    input wire logic sys_reset_pin_n_i,
    input wire logic reset_request_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////
    // pin 0 modes
    property p_in; sel_state_o[2:0] == 3'h0 |=> !pad_oe_o[0]; endproperty
    a_in: assert property (p_in) else $error("input pin drives");
    property p_out; sel_state_o[2:0] == 3'h1 |=> pad_oe_o[0] && pad_out_o[0] == $past(gpio_out_i[0]); endproperty
    a_out: assert property (p_out) else $error("output pin wrong");
    property p_irq; sel_state_o[2:0] == 3'h6 |=> !pad_oe_o[0] && port_c_interrupt_line_o[0] == $past(pad_in_i[0]); endproperty
    a_irq: assert property (p_irq) else $error("line not fed");
    property p_none; sel_state_o[2:0] == 3'h7 |=> !pad_oe_o[0] && !port_c_interrupt_line_o[0]; endproperty
    a_none: assert property (p_none) else $error("inactive pin active");
    // special pins
    property p_slow; sel_state_o[104:102] == 3'h3 |=> !pad_out_o[34] && pad_oe_o[34] == !$past(alt_out_i[137]); endproperty
    a_slow: assert property (p_slow) else $error("slow clock pin wrong");
    property p_dbg; sel_state_o[53:51] == 3'h3 |=> pad_oe_o[17] == ($past(debug_port_sel_i) && $past(alt_oe_i[69])); endproperty
    a_dbg: assert property (p_dbg) else $error("debug group wrong");
    // reset, strap and reset pin
    property p_rst; disable iff (1'b0) srst_i |=> sel_state_o == {74{3'h7}} && pad_oe_o == 74'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_boot; $rose(boot_mode_valid_o) |-> {media_boot_search_o, forced_upgrade_o} == {$past(boot_mode_strap_i), !$past(boot_mode_strap_i)}; endproperty
    a_boot: assert property (p_boot) else $error("boot choice wrong");
    property p_pin; !$past(srst_i) |-> reset_request_o == !$past(sys_reset_pin_n_i); endproperty
    a_pin: assert property (p_pin) else $error("reset request wrong");
endmodule : gfm_mux_monitor
`default_nettype wire

// *** test/gfm_mux_tb_top.sv ***
// self-checking bench for gfm_mux, one task a scenario
// assumes the pad model pulls undriven pins high
`timescale 1ns/1ns
`default_nettype none
module gfm_mux_tb_top;
    // design ports and bench state
    logic core_clk_i = 1'b0, srst_i = 1'b1, debug_port_sel_i = 1'b0, boot_mode_strap_i = 1'b1;
    logic sys_reset_pin_n_i = 1'b1, boot_mode_valid_o, media_boot_search_o, forced_upgrade_o;
    logic reset_request_o;
    logic [73:0] sel_wr_en_i = '0, gpio_out_i = '0, ext_v = '0, ext_en = '0;
    logic [73:0] pad_in_i, pad_out_o, pad_oe_o, gpio_in_o;
    logic [221:0] sel_wdata_i = '0, sel_state_o;
    logic [295:0] alt_out_i = '0, alt_oe_i = '0, alt_in_o;
    logic [16:0] port_c_interrupt_line_o, port_i_interrupt_line_o;
    logic [6:0] port_f_interrupt_line_o;
    logic [19:0] port_g_interrupt_line_o;
    logic [10:0] port_h_interrupt_line_o;
    logic [71:0] irq;
    logic [10:0] ae = 11'h7AD;
    int err_total = 0, n_checks = 0;
    int ap[11] = '{3, 3, 3, 3, 23, 72, 72, 60, 37, 44, 32};
    int av[11] = '{2, 3, 4, 5, 2, 2, 3, 4, 3, 4, 3};
    // flat line index equals flat pin index
    assign irq = {port_i_interrupt_line_o, port_h_interrupt_line_o, port_g_interrupt_line_o,
                  port_f_interrupt_line_o, port_c_interrupt_line_o};
    always #25 core_clk_i = ~core_clk_i;
    gfm_mux u_dut (
        .core_clk_i(core_clk_i), .srst_i(srst_i),
        .sel_wr_en_i(sel_wr_en_i), .sel_wdata_i(sel_wdata_i), .sel_state_o(sel_state_o),
        .gpio_out_i(gpio_out_i), .gpio_in_o(gpio_in_o),
        .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
        .alt_out_i(alt_out_i), .alt_oe_i(alt_oe_i), .alt_in_o(alt_in_o),
        .port_c_interrupt_line_o(port_c_interrupt_line_o),
        .port_f_interrupt_line_o(port_f_interrupt_line_o),
        .port_g_interrupt_line_o(port_g_interrupt_line_o),
        .port_h_interrupt_line_o(port_h_interrupt_line_o),
        .port_i_interrupt_line_o(port_i_interrupt_line_o),
        .debug_port_sel_i(debug_port_sel_i), .boot_mode_strap_i(boot_mode_strap_i),
        .boot_mode_valid_o(boot_mode_valid_o), .media_boot_search_o(media_boot_search_o),
        .forced_upgrade_o(forced_upgrade_o), .sys_reset_pin_n_i(sys_reset_pin_n_i),
        .reset_request_o(reset_request_o)
    );
    gfm_pad_model u_pads (.out_i(pad_out_o), .oe_i(pad_oe_o), .drv_i(ext_v), .drv_en_i(ext_en),
                          .pin_o(pad_in_i));
    ////////////////////////////////////////////////////////////////
    task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : ck
    task automatic nx();
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask : nx
    // one selection write, then wait until the pads follow
    task automatic ws(input int p, input logic [2:0] v);
        @(posedge core_clk_i);
        sel_wr_en_i <= 74'h1 << p;
        sel_wdata_i <= {74{v}};
        @(posedge core_clk_i);
        sel_wr_en_i <= '0;
        nx();
    endtask : ws
    task automatic t_boot(input logic s);
        @(posedge core_clk_i);
        srst_i <= 1'b1;
        boot_mode_strap_i <= s;
        repeat (6) @(posedge core_clk_i);
        srst_i <= 1'b0;
        #1;
        ck("sel_reset", 1, sel_state_o === {74{3'h7}});
        ck("oe_reset", 1, pad_oe_o === 74'h0);
        ck("boot_rst", 0, {boot_mode_valid_o, media_boot_search_o, forced_upgrade_o});
        nx();
        ck("valid", 1, boot_mode_valid_o);
        ck("search", s, media_boot_search_o);
        ck("upgrade", !s, forced_upgrade_o);
        $display("test boot %0d done", s);
    endtask : t_boot
    task automatic t_pins();
        for (int p = 0; p < 74; p++) begin
            @(posedge core_clk_i);
            gpio_out_i <= 74'h1 << p;
            ext_en <= '1;
            ext_v <= '0;
            ws(p, 3'h1);
            ck("gp_out", 1, pad_oe_o[p] & pad_out_o[p]);
            ws(p, 3'h0);
            ck("in_oe", 0, pad_oe_o[p]);
            ck("in_val", 0, gpio_in_o[p]);
            @(posedge core_clk_i);
            ext_v <= '1;
            ws(p, 3'h6);
            ck("irq_oe", 0, pad_oe_o[p]);
            ck("irq", 1, irq === (p < 72 ? 72'h1 << p : 72'h0));
            ws(p, 3'h7);
            ck("off", 1, {pad_oe_o[p], irq} === 73'h0);
        end
        $display("test pin modes done");
    endtask : t_pins
    task automatic t_alt();
        for (int i = 0; i < 11; i++) begin
            @(posedge core_clk_i);
            alt_oe_i <= '1;
            alt_out_i <= 296'h1 << (4 * ap[i] + av[i] - 2);
            ws(ap[i], av[i][2:0]);
            ck("alt_oe", ae[i], pad_oe_o[ap[i]]);
            ck("alt_out", ae[i], pad_oe_o[ap[i]] & pad_out_o[ap[i]]);
            ck("alt_in", ae[i], alt_in_o[4 * ap[i] + av[i] - 2]);
            ws(ap[i], 3'h7);
        end
        $display("test alternates done");
    endtask : t_alt
    task automatic t_dbg();
        @(posedge core_clk_i);
        debug_port_sel_i <= 1'b1;
        ws(17, 3'h3);
        ws(30, 3'h4);
        ws(19, 3'h3);
        ck("dbg", 1, {pad_oe_o[17], pad_oe_o[30], pad_oe_o[19]} === 3'h5);
        @(posedge core_clk_i);
        debug_port_sel_i <= 1'b0;
        nx();
        ck("dbg_swap", 1, {pad_oe_o[17], pad_oe_o[30], pad_oe_o[19]} === 3'h3);
        $display("test debug select done");
    endtask : t_dbg
    task automatic t_misc();
        @(posedge core_clk_i);
        alt_out_i <= '0;
        alt_oe_i <= '0;
        ws(34, 3'h3);
        ck("slow_low", 1, {pad_oe_o[34], pad_out_o[34]} === 2'h2);
        @(posedge core_clk_i);
        alt_out_i <= 296'h1 << 137;
        sys_reset_pin_n_i <= 1'b0;
        nx();
        ck("slow_rel", 0, pad_oe_o[34]);
        ck("rst_req", 1, reset_request_o);
        @(posedge core_clk_i);
        sys_reset_pin_n_i <= 1'b1;
        nx();
        ck("rst_idle", 0, reset_request_o);
        $display("test slow clock and reset pin done");
    endtask : t_misc
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    // main sequence and watchdog
    initial begin
        t_boot(1'b1);
        t_pins();
        t_alt();
        t_dbg();
        t_misc();
        t_boot(1'b0);
        summarize();
    end
    initial begin
        #500000;
        err_total++;
        summarize();
    end
endmodule : gfm_mux_tb_top
bind gfm_mux gfm_mux_monitor u_mon (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .sel_state_o(sel_state_o),
    .gpio_out_i(gpio_out_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
    .alt_out_i(alt_out_i), .alt_oe_i(alt_oe_i),
    .port_c_interrupt_line_o(port_c_interrupt_line_o),
    .debug_port_sel_i(debug_port_sel_i), .boot_mode_strap_i(boot_mode_strap_i),
    .boot_mode_valid_o(boot_mode_valid_o), .media_boot_search_o(media_boot_search_o),
    .forced_upgrade_o(forced_upgrade_o), .sys_reset_pin_n_i(sys_reset_pin_n_i),
    .reset_request_o(reset_request_o)
);
`default_nettype wire
